// ==== core/ect_cmp_if.sv ====
`timescale 1ns/1ps
// ===================================================================
// Compare events and output selection passed to the waveform unit.
interface ect_cmp_if;
  logic match_a;
  logic match_b;
  logic [3:0] out_sel;
  logic hold;
  logic wave_r;
  modport core (output match_a, output match_b, output out_sel, output hold, input wave_r);
  modport wave (input match_a, input match_b, input out_sel, input hold, output wave_r);
endinterface

// ==== core/ect_pkg.sv ====
package ect_pkg;

  // ===================================================================
  // Register map (byte offsets on the 3-bit register port)
  localparam logic [2:0] A_CNT = 3'h0;
  localparam logic [2:0] A_CMPA = 3'h1;
  localparam logic [2:0] A_CMPB = 3'h2;
  localparam logic [2:0] A_CTL0 = 3'h3;
  localparam logic [2:0] A_CTL1 = 3'h4;
  localparam logic [2:0] A_CSR = 3'h5;

  // ===================================================================
  // Reset values and reserved read-as-one masks
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hFF;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL1_WMASK = 8'h1D;
  localparam logic [7:0] CTL1_RSV = 8'hE2;
  localparam logic [7:0] CSR_RSV = 8'h10;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] FLG_RST = 3'h0;
  localparam logic [3:0] OS_RST = 4'h0;

  // ===================================================================
  // Field positions
  localparam int FLG_HI = 7;
  localparam int FLG_LO = 5;
  localparam int CCL_HI = 4;
  localparam int CCL_LO = 3;
  localparam int CKS_HI = 2;
  localparam int TEG_HI = 4;
  localparam int TEG_LO = 3;
  localparam int ARM_BIT = 2;
  localparam int ICK_BIT = 0;
  localparam int OS_HI = 3;
  localparam int PS_W = 7;

  // ===================================================================
  // Encodings
  typedef enum logic [1:0] {
    OUT_KEEP = 2'h0,
    OUT_LOW = 2'h1,
    OUT_HIGH = 2'h2,
    OUT_TOG = 2'h3
  } ect_act_t;

  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_PIN = 2'h3;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;
  localparam logic [2:0] CKS_EXT_R = 3'h5;
  localparam logic [2:0] CKS_EXT_F = 3'h6;
  localparam logic [2:0] CKS_EXT_B = 3'h7;
  localparam logic [2:0] TAP_TOP = 3'h5;
  localparam logic [1:0] CKS_ONE = 2'h1;

endpackage

// ==== core/ect_prescale.sv ====
`timescale 1ns/1ps
// ===================================================================
// Free-running divider; taps[0] is clk/4 up to taps[5] at clk/128.
module ect_prescale
  import ect_pkg::*;
#(
  parameter int W = PS_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  output logic [W-2:0] taps
);

  logic [W-1:0] div_r;

  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign taps = div_r[W-1:1];

endmodule

// ==== core/ect_timer.sv ====
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
// How it works
// - In low-power hold every register and output sits at its reset value.
// - Match A, match B and wrap flags each gate one shared interrupt.
// - Clear in the counter write cycle wins; written value is dropped.
// - Count tick in the counter write cycle is dropped; write wins.
// - Writing a compare register masks that register's match this cycle.
// - Conflicting pin actions resolve toggle, then drive-1, drive-0, no-change.
// - Internal source counts on falling edge, including falls caused by switching.
// - Switching between internal and external source may give one count.
// - Clear select 01 match A, 10 match B, 11 clear-pin rising edge.
// - Upper output pair acts on match B, lower on match A.
// - A match fires on the count tick leaving the equal value.
// - Arming halts counting; trigger edge starts, selected clear halts again.
module ect_timer
  import ect_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lp_hold,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic ext_count_pin,
  input wire logic trigger_pin,
  input wire logic ext_clear_pin,
  output logic wave_out_pin,
  output logic irq
);

  // ===================================================================
  // Registers

  logic [7:0] cnt_r;
  logic [7:0] cmpa_r;
  logic [7:0] cmpb_r;
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [2:0] flags_r;
  logic [3:0] os_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic halted_r;
  logic src_prev_r;
  logic ext_prev_r;
  logic trig_prev_r;
  logic clrpin_prev_r;

  logic [5:0] taps;
  logic hold;
  logic wr_cnt;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_ctl1;
  logic wr_csr;
  logic [2:0] cks;
  logic [1:0] ccl;
  logic [1:0] teg;
  logic arm;
  logic ick;
  logic src;
  logic inc_pulse;
  logic tick;
  logic eq_a;
  logic eq_b;
  logic match_a;
  logic match_b;
  logic clr;
  logic trig_hit;
  logic arm_set;
  logic wrap;
  logic [2:0] flags_nxt;

  ect_cmp_if cif ();

  assign hold = lp_hold;

  // ===================================================================
  // Field decode

  assign cks = ctl0_r[CKS_HI:0];
  assign ccl = ctl0_r[CCL_HI:CCL_LO];
  assign teg = ctl1_r[TEG_HI:TEG_LO];
  assign arm = ctl1_r[ARM_BIT];
  assign ick = ctl1_r[ICK_BIT];

  assign wr_cnt = wr_en && addr == A_CNT;
  assign wr_cmpa = wr_en && addr == A_CMPA;
  assign wr_cmpb = wr_en && addr == A_CMPB;
  assign wr_ctl1 = wr_en && addr == A_CTL1;
  assign wr_csr = wr_en && addr == A_CSR;

  // ===================================================================
  // Count source and increment pulse

  ect_prescale u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .hold(hold),
    .taps(taps)
  );

  // Except in both-edge mode, the source is reduced to one level whose falling edge is a count.
  // A register write that changes the selection can therefore produce
  // a fall by itself, which counts exactly like a real clock edge.
  always_comb begin
    unique case (cks)
      3'h1, 3'h2, 3'h3: src = taps[TAP_TOP - {cks[1:0] - CKS_ONE, ick}];
      CKS_EXT_R: src = ~ext_count_pin;
      CKS_EXT_F: src = ext_count_pin;
      CKS_EXT_B: src = ext_count_pin;
      default: src = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      src_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
      trig_prev_r <= 1'b0;
      clrpin_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src;
      ext_prev_r <= ext_count_pin;
      trig_prev_r <= trigger_pin;
      clrpin_prev_r <= ext_clear_pin;
    end
  end

  assign inc_pulse = (cks == CKS_EXT_B) ? (ext_count_pin != ext_prev_r)
                                        : (src_prev_r && !src);
  assign tick = inc_pulse && !(arm && halted_r);

  // ===================================================================
  // Compare, clear and wrap

  assign eq_a = cnt_r == cmpa_r;
  assign eq_b = cnt_r == cmpb_r;
  assign match_a = tick && eq_a && !wr_cmpa;
  assign match_b = tick && eq_b && !wr_cmpb;

  always_comb begin
    unique case (ccl)
      CLR_A: clr = match_a;
      CLR_B: clr = match_b;
      CLR_PIN: clr = ext_clear_pin && !clrpin_prev_r;
      default: clr = 1'b0;
    endcase
  end

  assign wrap = tick && cnt_r == CNT_MAX && !clr && !wr_cnt;

  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      cnt_r <= CNT_RST;
    end else if (clr) begin
      cnt_r <= CNT_RST;
    end else if (wr_cnt) begin
      cnt_r <= wdata;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // ===================================================================
  // Trigger gate

  always_comb begin
    unique case (teg)
      EDG_RISE: trig_hit = trigger_pin && !trig_prev_r;
      EDG_FALL: trig_hit = !trigger_pin && trig_prev_r;
      EDG_BOTH: trig_hit = trigger_pin != trig_prev_r;
      default: trig_hit = 1'b0;
    endcase
  end

  assign arm_set = wr_ctl1 && wdata[ARM_BIT] && !arm;

  // Arming always halts, even if a trigger edge lands in the same cycle,
  // so software sees a defined stopped state right after setting the bit.
  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      halted_r <= 1'b0;
    end else if (arm_set) begin
      halted_r <= 1'b1;
    end else if (trig_hit) begin
      halted_r <= 1'b0;
    end else if (clr && arm) begin
      halted_r <= 1'b1;
    end
  end

  // ===================================================================
  // Software registers

  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      cmpa_r <= CMP_RST;
      cmpb_r <= CMP_RST;
      ctl0_r <= CTL0_RST;
      ctl1_r <= CTL1_RST;
      os_r <= OS_RST;
    end else begin
      if (wr_cmpa) begin
        cmpa_r <= wdata;
      end
      if (wr_cmpb) begin
        cmpb_r <= wdata;
      end
      if (wr_en && addr == A_CTL0) begin
        ctl0_r <= wdata;
      end
      if (wr_ctl1) begin
        ctl1_r <= wdata & CTL1_WMASK;
      end
      if (wr_csr) begin
        os_r <= wdata[OS_HI:0];
      end
    end
  end

  // A new event in the same cycle as a write-one clear keeps its flag.
  always_comb begin
    flags_nxt = flags_r;
    if (wr_csr) begin
      flags_nxt = flags_r & ~wdata[FLG_HI:FLG_LO];
    end
    flags_nxt = flags_nxt | {match_b, match_a, wrap};
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      flags_r <= FLG_RST;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq_r <= |(flags_r & ctl0_r[FLG_HI:FLG_LO]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      rdata_r <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        A_CNT: rdata_r <= cnt_r;
        A_CMPA: rdata_r <= cmpa_r;
        A_CMPB: rdata_r <= cmpb_r;
        A_CTL0: rdata_r <= ctl0_r;
        A_CTL1: rdata_r <= ctl1_r | CTL1_RSV;
        A_CSR: rdata_r <= {flags_r, 1'b0, os_r} | CSR_RSV;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ===================================================================
  // Waveform unit and outputs

  assign cif.match_a = match_a;
  assign cif.match_b = match_b;
  assign cif.out_sel = os_r;
  assign cif.hold = hold;

  ect_wave u_wave (
    .clk(clk),
    .rst_n(rst_n),
    .cif(cif.wave)
  );

  assign wave_out_pin = cif.wave_r;
  assign irq = irq_r;
  assign rdata = rdata_r;

  // ===================================================================
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_armed_idle;
    !hold && arm && halted_r && !trig_hit && !wr_cnt && !clr;
  endsequence

  sequence s_trig_start;
    !hold && arm && halted_r && trig_hit && !arm_set;
  endsequence

  hold_reset_a: assert property (
    hold |=> cnt_r == CNT_RST && cmpa_r == CMP_RST && !irq && !wave_out_pin)
    else $error("state not reset in hold");
  irq_level_a: assert property (
    !hold && |(flags_r & ctl0_r[FLG_HI:FLG_LO]) |=> irq)
    else $error("enabled flag without interrupt");
  clr_wins_a: assert property (
    !hold && clr && wr_cnt |=> cnt_r == CNT_RST)
    else $error("write beat a clear");
  wr_wins_a: assert property (
    !hold && wr_cnt && tick && !clr |=> cnt_r == $past(wdata))
    else $error("tick beat a write");
  cmp_wr_a: assert property (
    !hold && wr_cmpa && tick && eq_a && !flags_r[1] |=> !flags_r[1])
    else $error("match during compare write");
  leave_match_a: assert property (
    !hold && match_a && !clr && !wr_cnt |=> cnt_r == $past(cmpa_r) + 8'h01)
    else $error("match not on leaving count");
  clear_sel_a: assert property (
    !hold && ccl == CLR_B && match_b |=> cnt_r == CNT_RST)
    else $error("clear on match B missed");
  wrap_flag_a: assert property (
    !hold && wrap |=> flags_r[0] && cnt_r == CNT_RST)
    else $error("wrap not flagged");
  fall_count_a: assert property (
    !hold && !cks[CKS_HI] && |cks[1:0] && src_prev_r && !src && !arm && !clr && !wr_cnt
    |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("falling source did not count");
  halt_a: assert property (
    s_armed_idle |=> cnt_r == $past(cnt_r))
    else $error("counted while halted");
  trig_start_a: assert property (
    s_trig_start |=> !halted_r)
    else $error("trigger did not start count");
  both_edge_a: assert property (
    !hold && cks == CKS_EXT_B && ext_count_pin != ext_prev_r && !arm && !clr && !wr_cnt
    |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("pin change in both-edge mode did not count");
  irq_off_a: assert property (
    !hold && !(|(flags_r & ctl0_r[FLG_HI:FLG_LO])) |=> !irq)
    else $error("interrupt without an enabled flag");
  arm_halt_a: assert property (
    !hold && arm_set |=> halted_r)
    else $error("arming did not halt the count");
  clr_pin_a: assert property (
    !hold && ccl == CLR_PIN && ext_clear_pin && !clrpin_prev_r |=> cnt_r == CNT_RST)
    else $error("clear-pin edge missed");
  halt_clr_a: assert property (
    !hold && arm && clr && !arm_set && !trig_hit |=> halted_r)
    else $error("selected clear did not halt");

endmodule

// ==== core/ect_wave.sv ====
`timescale 1ns/1ps
// ===================================================================
// Waveform pin driver with match A/B conflict resolution.
module ect_wave
  import ect_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ect_cmp_if.wave cif
);

  ect_act_t act_a;
  ect_act_t act_b;
  ect_act_t act;

  // Priority order equals numeric order of the codes, so the larger wins.
  function automatic ect_act_t pick(input ect_act_t x, input ect_act_t y);
    pick = (x > y) ? x : y;
  endfunction

  always_comb begin
    act_a = cif.match_a ? ect_act_t'(cif.out_sel[1:0]) : OUT_KEEP;
    act_b = cif.match_b ? ect_act_t'(cif.out_sel[OS_HI:2]) : OUT_KEEP;
    act = pick(act_a, act_b);
  end

  always_ff @(posedge clk) begin
    if (!rst_n || cif.hold) begin
      cif.wave_r <= 1'b0;
    end else begin
      unique case (act)
        OUT_KEEP: cif.wave_r <= cif.wave_r;
        OUT_LOW: cif.wave_r <= 1'b0;
        OUT_HIGH: cif.wave_r <= 1'b1;
        OUT_TOG: cif.wave_r <= ~cif.wave_r;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || cif.hold);

  tog_wins_a: assert property (
    (act_a == OUT_TOG || act_b == OUT_TOG) |=> cif.wave_r != $past(cif.wave_r))
    else $error("toggle did not win");
  high_over_low_a: assert property (
    act_a == OUT_HIGH && act_b == OUT_LOW |=> cif.wave_r)
    else $error("drive-1 lost to drive-0");
  keep_a: assert property (
    !cif.match_a && !cif.match_b |=> $stable(cif.wave_r))
    else $error("pin moved without a match");

endmodule

// ==== tb/ect_pins_model.sv ====
`timescale 1ns/1ps
// ===================================================================
// Far-side pins: count clock bursts, trigger pulses, clear pulses.
module ect_pins_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] n,
  input wire logic slow,
  input wire logic trig_go,
  input wire logic clr_go,
  output logic busy,
  output logic ext_count_pin,
  output logic trigger_pin,
  output logic ext_clear_pin
);
  logic [4:0] rem_r;
  logic [2:0] ph_r;
  logic [1:0] tg_r;
  logic [1:0] cl_r;
  // Each level lasts at least two clocks, or a single-edge count could be lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rem_r <= 5'h00;
      ph_r <= 3'h0;
      ext_count_pin <= 1'b1;
    end else if (go) begin
      rem_r <= {n, 1'b0};
      ph_r <= 3'h0;
    end else if (rem_r != 5'h00) begin
      if (ph_r == (slow ? 3'h4 : 3'h1)) begin
        ph_r <= 3'h0;
        rem_r <= rem_r - 5'h01;
        ext_count_pin <= ~ext_count_pin;
      end else begin
        ph_r <= ph_r + 3'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tg_r <= 2'h0;
      cl_r <= 2'h0;
    end else begin
      tg_r <= trig_go ? 2'h3 : (tg_r == 2'h0 ? 2'h0 : tg_r - 2'h1);
      cl_r <= clr_go ? 2'h3 : (cl_r == 2'h0 ? 2'h0 : cl_r - 2'h1);
    end
  end
  assign busy = rem_r != 5'h00;
  assign trigger_pin = tg_r == 2'h0;
  assign ext_clear_pin = cl_r != 2'h0;
endmodule

// ==== tb/ect_timer_tb.sv ====
`timescale 1ns/1ps
module ect_timer_tb;
  import ect_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lp_hold = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic go = 1'b0;
  logic [3:0] n = 4'h0;
  logic slow = 1'b0;
  logic trig_go = 1'b0;
  logic clr_go = 1'b0;
  logic [7:0] rdata;
  logic busy, cpin, tpin, kpin, wave, irq, w;
  logic [31:0] rs = 32'h0000001E;
  logic [7:0] ca, cb, v, got;
  logic [3:0] os_tab [3] = '{4'hB, 4'h9, 4'h4};
  int miscompares = 0;
  int compares = 0;
  always #2 clk = ~clk;
  ect_timer ect_timer_i (.clk(clk), .rst_n(rst_n), .lp_hold(lp_hold), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_count_pin(cpin),
    .trigger_pin(tpin), .ext_clear_pin(kpin), .wave_out_pin(wave), .irq(irq));
  ect_pins_model ect_pins_model_i (.clk(clk), .rst_n(rst_n), .go(go), .n(n), .slow(slow),
    .trig_go(trig_go), .clr_go(clr_go), .busy(busy), .ext_count_pin(cpin),
    .trigger_pin(tpin), .ext_clear_pin(kpin));
  // ===================================================================
  // Expectation helpers
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  function automatic logic wave_next(input logic p, input logic [3:0] os);
    logic [1:0] act;
    act = (os[3:2] > os[1:0]) ? os[3:2] : os[1:0];
    case (act)
      2'h0: return p;
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      default: return ~p;
    endcase
  endfunction
  // ===================================================================
  // Bus and pin tasks
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdv(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rdv(a);
    chk(got, e);
  endtask
  task automatic start(input logic [3:0] k);
    @(posedge clk);
    n <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] k);
    int i;
    start(k);
    @(posedge clk);
    for (i = 0; busy !== 1'b0; i++) begin
      if (i == 300) begin
        miscompares++;
        $display("mismatch at %0t ns: pin model never went idle", $time);
        print_verdict();
      end
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic pin_pulse(input logic trig);
    @(posedge clk);
    trig_go <= trig;
    clr_go <= ~trig;
    @(posedge clk);
    trig_go <= 1'b0;
    clr_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // ===================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CNT, CNT_RST);
    rd(A_CMPA, CMP_RST);
    rd(A_CMPB, CMP_RST);
    rd(A_CTL0, CTL0_RST);
    rd(A_CTL1, 8'hE2);
    rd(A_CSR, CSR_RSV);
    v = rnd();
    ca = {1'b0, v[6:0]};
    wr(A_CMPA, ca);
    rd(A_CMPA, ca);
    // The last of the back-to-back counter writes lands on the second count tick.
    wr(A_CTL0, 8'h06);
    v = ca ^ 8'h40;
    start(4'h2);
    addr <= A_CNT;
    wdata <= v;
    wr_en <= 1'b1;
    repeat (7) @(posedge clk);
    wr_en <= 1'b0;
    rd(A_CNT, v);
    // Same timing: the last compare write meets the tick that leaves the equal count.
    wr(A_CNT, 8'h20);
    start(4'h2);
    addr <= A_CMPA;
    wdata <= 8'h21;
    wr_en <= 1'b1;
    repeat (7) @(posedge clk);
    wr_en <= 1'b0;
    rd(A_CSR, CSR_RSV);
    rd(A_CNT, 8'h22);
    wr(A_CTL0, 8'h26);
    wr(A_CNT, 8'hFF);
    pulse(4'h1);
    rd(A_CNT, 8'h00);
    rd(A_CSR, 8'hB0);
    chk({7'h00, irq}, 8'h01);
    wr(A_CTL0, 8'h06);
    rd(A_CSR, 8'hB0);
    chk({7'h00, irq}, 8'h00);
    wr(A_CSR, 8'hE0);
    rd(A_CSR, CSR_RSV);
    v = rnd();
    cb = 8'h01 + {6'h00, v[1:0]};
    ca = cb + 8'h01 + {6'h00, v[3:2]};
    wr(A_CNT, 8'h00);
    wr(A_CMPA, ca);
    wr(A_CMPB, cb);
    wr(A_CSR, 8'h06);
    wr(A_CTL0, 8'h4E);
    slow <= 1'b1;
    pulse(ca[3:0]);
    rd(A_CNT, ca);
    rd(A_CSR, 8'h96);
    chk({7'h00, wave}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    pulse(4'h1);
    rd(A_CNT, 8'h00);
    rd(A_CSR, 8'hD6);
    chk({7'h00, wave}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    slow <= 1'b0;
    wr(A_CTL0, 8'h06);
    wr(A_CMPA, 8'h01);
    wr(A_CMPB, 8'h01);
    w = 1'b1;
    foreach (os_tab[i]) begin
      wr(A_CNT, 8'h00);
      wr(A_CSR, {4'h0, os_tab[i]});
      pulse(4'h2);
      w = wave_next(w, os_tab[i]);
      chk({7'h00, wave}, {7'h00, w});
    end
    wr(A_CSR, 8'hE6);
    wr(A_CMPB, 8'h03);
    wr(A_CTL0, 8'h16);
    wr(A_CNT, 8'h00);
    wr(A_CTL1, 8'h14);
    rd(A_CTL1, 8'hF6);
    pulse(4'h3);
    rd(A_CNT, 8'h00);
    pin_pulse(1'b1);
    pulse(4'h2);
    rd(A_CNT, 8'h02);
    chk({7'h00, wave}, 8'h01);
    pulse(4'h4);
    rd(A_CNT, 8'h00);
    chk({7'h00, wave}, 8'h00);
    // Rising trigger edge restarts a counter halted by the match B clear.
    wr(A_CTL1, 8'h0C);
    pin_pulse(1'b1);
    pulse(4'h1);
    rd(A_CNT, 8'h01);
    wr(A_CTL1, 8'h00);
    wr(A_CTL0, 8'h1E);
    // The clear-pin edge and a counter write land on the same edge.
    @(posedge clk);
    clr_go <= 1'b1;
    @(posedge clk);
    clr_go <= 1'b0;
    addr <= A_CNT;
    wdata <= 8'h55;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd(A_CNT, 8'h00);
    wr(A_CTL0, 8'h07);
    wr(A_CNT, 8'h00);
    pulse(4'h2);
    rd(A_CNT, 8'h04);
    // Going from falling to rising mode with the pin high looks like a fall.
    wr(A_CTL0, 8'h06);
    wr(A_CNT, 8'h00);
    wr(A_CTL0, 8'h05);
    rd(A_CNT, 8'h01);
    pulse(4'h2);
    rd(A_CNT, 8'h03);
    // The clk/4 tap may add one count when it is switched off, hence the window.
    wr(A_CTL0, 8'h00);
    wr(A_CNT, 8'h00);
    wr(A_CTL1, 8'h01);
    wr(A_CTL0, 8'h03);
    repeat (64) @(posedge clk);
    wr(A_CTL0, 8'h00);
    rdv(A_CNT);
    chk({7'h00, got >= 8'h0F && got <= 8'h12}, 8'h01);
    wr(3'h6, 8'hA5);
    rd(3'h6, 8'h00);
    wr(A_CMPA, 8'h12);
    lp_hold <= 1'b1;
    repeat (3) @(posedge clk);
    lp_hold <= 1'b0;
    rd(A_CMPA, CMP_RST);
    rd(A_CTL1, 8'hE2);
    print_verdict();
  end
endmodule
